/* core/ddec_cfg.svh */
// Constants for the dual decoder driver.
// Assumes inclusion by bare name from core files.
`ifndef DDEC_CFG_SVH
`define DDEC_CFG_SVH
// Decoder pin propagation allowance, in ns, and in cycles of sys_clk
`define DDEC_CLK_PERIOD_NS 100
`define DDEC_SETTLE_NS 34
`define DDEC_SETTLE_CYC (((`DDEC_SETTLE_NS) + (`DDEC_CLK_PERIOD_NS) - 1) / (`DDEC_CLK_PERIOD_NS))
// Mode encodings
`define DDEC_MODE_DUAL 2'h0
`define DDEC_MODE_DEC8 2'h1
`define DDEC_MODE_DMX8 2'h2
`define DDEC_MODE_DMX4 2'h3
`endif

/* core/ddec_pkg.sv */
// Types for the dual decoder driver.
// Assumes ddec_cfg.svh is compiled alongside.
package ddec_pkg;
   typedef enum logic [1:0] {
      DDEC_IDLE = 2'h0,
      DDEC_SETUP = 2'h1,
      DDEC_ACTIVE = 2'h3,
      DDEC_RELEASE = 2'h2
   } ddec_state_t;
endpackage : ddec_pkg

/* core/ddec_host.sv */
// Driver for an external dual 2-to-4 decoder.
// Assumes decoder pins are wired straight to the outputs below.
// Behaviour
// [R1] Selects encode index, sel_hi upper bit
// [R2] Both sections share the select pair
// [R3] Strobe high forces section outputs high
// [R4] Section one needs strobe low, data high
// [R5] Section two needs strobe and data low
// [R6] Section one data inverted, two not
// [R7] Demux: serial data on both data inputs
// [R8] Eight-way: joined data is third select
// [R9] Eight-way: joined strobe enables one output
// [R10] Eight-way demux: joined strobe carries data
// [R11] Strobes high while selects change
// [R12] Device is purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "ddec_cfg.svh"
module ddec_host (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // Request
   input wire logic req_valid,
   input wire logic [1:0] req_mode,
   input wire logic [2:0] req_index,
   input wire logic req_data,
   input wire logic req_sec_one,
   input wire logic req_sec_two,
   output logic req_ready,
   // Decoder pins
   output logic sel_lo,
   output logic sel_hi,
   output logic strobe_one_n,
   output logic strobe_two_n,
   output logic d_in_one,
   output logic d_in_two
);

   // Sequencer state
   ddec_pkg::ddec_state_t state_reg;
   ddec_pkg::ddec_state_t state_next;
   logic [1:0] cnt_reg;
   logic [1:0] cnt_next;
   logic ready_reg;
   logic ready_next;

   // Latched request
   logic [1:0] mode_reg;
   logic [1:0] mode_next;
   logic [2:0] idx_reg;
   logic [2:0] idx_next;
   logic dat_reg;
   logic dat_next;
   logic en1_reg;
   logic en1_next;
   logic en2_reg;
   logic en2_next;

   // Pin registers
   logic sl_reg;
   logic sl_next;
   logic sh_reg;
   logic sh_next;
   logic s1_reg;
   logic s1_next;
   logic s2_reg;
   logic s2_next;
   logic d1_reg;
   logic d1_next;
   logic d2_reg;
   logic d2_next;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      mode_next = mode_reg;
      idx_next = idx_reg;
      dat_next = dat_reg;
      en1_next = en1_reg;
      en2_next = en2_reg;
      ready_next = ready_reg;

      sl_next = sl_reg;
      sh_next = sh_reg;
      s1_next = 1'b1;
      s2_next = 1'b1;
      d1_next = d1_reg;
      d2_next = d2_reg;

      case (state_reg)
         // Wait for a request
         ddec_pkg::DDEC_IDLE: begin
            ready_next = 1'b1;
            if (req_valid && ready_reg) begin
               ready_next = 1'b0;
               mode_next = req_mode;
               idx_next = req_index;
               dat_next = req_data;
               en1_next = req_sec_one;
               en2_next = req_sec_two;
               // Selects move while strobes stay high
               sl_next = req_index[0]; // [R11] [R2]
               sh_next = req_index[1]; // [R1]
               // Data pins per mode
               case (req_mode)
                  `DDEC_MODE_DUAL: begin
                     d1_next = 1'b1; // [R4]
                     d2_next = 1'b0; // [R5]
                  end

                  `DDEC_MODE_DMX4: begin
                     d1_next = ~req_data; // [R7] [R6]
                     d2_next = req_data; // [R7] [R6]
                  end

                  default: begin
                     d1_next = req_index[2]; // [R8]
                     d2_next = req_index[2]; // [R8]
                  end
               endcase

               cnt_next = 2'(`DDEC_SETTLE_CYC);
               state_next = ddec_pkg::DDEC_SETUP;
            end
         end

         // Selects settle with strobes high
         ddec_pkg::DDEC_SETUP: begin
            if (cnt_reg == 2'h0) begin
               state_next = ddec_pkg::DDEC_ACTIVE;
               cnt_next = 2'(`DDEC_SETTLE_CYC);
            end else begin
               cnt_next = cnt_reg - 2'h1;
            end
         end

         // Strobe window
         ddec_pkg::DDEC_ACTIVE: begin
            // Lower strobes only once selects are stable
            case (mode_reg)
               `DDEC_MODE_DEC8: begin
                  s1_next = 1'b0; // [R9]
                  s2_next = 1'b0; // [R9]
               end
               `DDEC_MODE_DMX8: begin
                  s1_next = dat_reg; // [R10]
                  s2_next = dat_reg; // [R10]
               end
               default: begin
                  s1_next = ~en1_reg; // [R3]
                  s2_next = ~en2_reg; // [R3]
               end
            endcase
            if (cnt_reg == 2'h0) begin
               s1_next = 1'b1;
               s2_next = 1'b1;
               state_next = ddec_pkg::DDEC_RELEASE;
            end else begin
               cnt_next = cnt_reg - 2'h1;
            end
         end

         // Release, then ready again
         default: begin
            ready_next = 1'b1;
            state_next = ddec_pkg::DDEC_IDLE;
         end
      endcase
   end

   // Sequencer and latched request
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_reg <= ddec_pkg::DDEC_IDLE;
         cnt_reg <= 2'h0;
         mode_reg <= 2'h0;
         idx_reg <= 3'h0;
         dat_reg <= 1'b0;
         en1_reg <= 1'b0;
         en2_reg <= 1'b0;
         ready_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         mode_reg <= mode_next;
         idx_reg <= idx_next;
         dat_reg <= dat_next;
         en1_reg <= en1_next;
         en2_reg <= en2_next;
         ready_reg <= ready_next;
      end
   end

   // Outputs registered; device needs no clock of its own
   always_ff @(posedge sys_clk) begin // [R12]
      if (srst) begin
         sl_reg <= 1'b0;
         sh_reg <= 1'b0;
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         d1_reg <= 1'b0;
         d2_reg <= 1'b1;
      end else begin
         sl_reg <= sl_next;
         sh_reg <= sh_next;
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         d1_reg <= d1_next;
         d2_reg <= d2_next;
      end
   end

   // Every output straight from a flip-flop
   assign req_ready = ready_reg;
   assign sel_lo = sl_reg;
   assign sel_hi = sh_reg;
   assign strobe_one_n = s1_reg;
   assign strobe_two_n = s2_reg;
   assign d_in_one = d1_reg;
   assign d_in_two = d2_reg;
endmodule : ddec_host
`default_nettype wire

/* tb/ddec_dev_model.sv */
// Decoder model on the far side of ddec_host.
// Assumes pins wired straight from the driver.
`timescale 1ns/10ps
`default_nettype none
module ddec_dev_model (
   // Pins in
   input wire logic sel_lo, sel_hi, strobe_one_n, strobe_two_n,
   input wire logic d_in_one, d_in_two,
   // Outputs, active low
   output logic [3:0] y_one_n, y_two_n
);
   always_comb begin
      y_one_n = 4'hF;
      y_two_n = 4'hF;
      if (!strobe_one_n && d_in_one)
         y_one_n[{sel_hi, sel_lo}] = 1'b0;
      if (!strobe_two_n && !d_in_two)
         y_two_n[{sel_hi, sel_lo}] = 1'b0;
   end
endmodule : ddec_dev_model
`default_nettype wire

/* tb/ddec_host_assertions.sv */
// Port checks for ddec_host.
// Bound to every ddec_host instance.
`timescale 1ns/10ps
`default_nettype none
module ddec_host_assertions (
   // Clock, reset, request
   input wire logic sys_clk, srst, req_valid, req_data, req_ready,
   input wire logic [1:0] req_mode,
   input wire logic [2:0] req_index,
   // Pins
   input wire logic sel_lo, sel_hi, strobe_one_n, strobe_two_n,
   input wire logic d_in_one, d_in_two
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   sequence take; req_valid && req_ready; endsequence
   sequence quiet; strobe_one_n && strobe_two_n; endsequence
   a_sel_index: assert property (
      take |=> {sel_hi, sel_lo} == $past(req_index[1:0])) else $error("sel");
   a_strobe_quiet: assert property (take |=> quiet [*2])
      else $error("early strobe");
   a_ready_gap: assert property (
      take |=> !req_ready [*5] ##1 req_ready) else $error("ready");
   a_pulse_once: assert property (!strobe_one_n |=> strobe_one_n)
      else $error("strobe width");
   a_dual_data: assert property (
      take and (req_mode == 2'h0) |=> d_in_one && !d_in_two)
      else $error("dual");
   a_dmx4_data: assert property (
      take and (req_mode == 2'h3) |=> d_in_two == $past(req_data)
      && d_in_one != d_in_two) else $error("dmx4");
   a_dec8_join: assert property (
      take and (req_mode == 2'h1) |-> ##4 !strobe_one_n && !strobe_two_n
      && d_in_one == d_in_two && d_in_two == $past(req_index[2], 4))
      else $error("dec8");
   a_dmx8_data: assert property (
      take and (req_mode == 2'h2) |-> ##4 strobe_one_n == $past(req_data, 4)
      && strobe_two_n == strobe_one_n) else $error("dmx8");
endmodule : ddec_host_assertions
bind ddec_host ddec_host_assertions chk_u (.*);
`default_nettype wire

/* tb/ddec_host_tb_top.sv */
// Bench for ddec_host driving the decoder model.
// Assumes the checker is bound in.
`timescale 1ns/10ps
`default_nettype none
module ddec_host_tb_top;
   logic sys_clk = 0, srst = 1, req_valid = 0, req_data = 0;
   logic req_sec_one = 0, req_sec_two = 0, req_ready;
   logic [1:0] req_mode = 0;
   logic [2:0] req_index = 0;
   logic sel_lo, sel_hi, strobe_one_n, strobe_two_n, d_in_one, d_in_two;
   logic [3:0] y_one_n, y_two_n;
   int bad_count = 0, n_compared = 0;
   always #50 sys_clk = ~sys_clk;
   ddec_host dut_u (.*);
   ddec_dev_model dev_u (.*);
   task tally_and_finish;
      if (bad_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   task cmp(logic [7:0] e);
      n_compared++;
      if ({y_one_n, y_two_n} !== e) begin
         bad_count++;
         $display("[ERR] %0t out %h exp %h", $time, {y_one_n, y_two_n}, e);
      end
   endtask : cmp
   task run(int m, int i, int d, int s1, int s2);
      logic [7:0] e;
      int n;
      e = 8'hFF;
      n = 0;
      if (m == 1) e[i] = 1'b0;
      if (m == 2) e[i] = d[0];
      if (m % 3 == 0 && s1) e[4 + i % 4] = m == 3 ? d[0] : 1'b0;
      if (m % 3 == 0 && s2) e[i % 4] = m == 3 ? d[0] : 1'b0;
      @(negedge sys_clk);
      while (req_ready !== 1'b1) begin
         @(negedge sys_clk);
         if (++n > 20) begin bad_count++; tally_and_finish; end
      end
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req_mode <= m[1:0];
      req_index <= i[2:0];
      req_data <= d[0];
      req_sec_one <= s1[0];
      req_sec_two <= s2[0];
      @(posedge sys_clk);
      req_valid <= 1'b0;
      for (int k = 0; k < 5; k++) begin
         @(negedge sys_clk);
         cmp(k == 3 ? e : 8'hFF);
      end
   endtask : run
   initial begin
      void'($urandom(32'h3D238A33));
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      for (int t = 0; t < 64; t++)
         run(t % 4, $urandom % 8, $urandom % 2, $urandom % 2, $urandom % 2);
      tally_and_finish;
   end
endmodule : ddec_host_tb_top
`default_nettype wire
